/* crsf_regs.sv */
// Local design decisions: the register offsets and the Avalon-MM register port.
module crsf_regs
  import crsf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // datapath access
  input  wire crsf_access_t dpRd,
  output logic      [31:0] dpRdData,
  input  wire crsf_access_t dpWr,
  // alu and interrupt events
  input  wire crsf_alu_t   alu,
  input  wire crsf_event_t ev,
  input  wire crsf_irq_t   irq,
  output logic             irqAccept,
  output logic             stepIrq,
  // architectural state
  output logic      [19:0] programCounter,
  output logic      [15:0] processorFlags
);

  logic [15:0]     dataReg [2][4];
  logic [15:0]     addrReg [2][2];
  logic [15:0]     frameBase [2];
  logic [19:0]     vectorTableBase;
  logic [15:0]     userStackPtr;
  logic [15:0]     irqStackPtr;
  logic [15:0]     staticBase;
  logic            bankSel;
  logic [15:0]     activeSp;
  crsf_access_t    wr;
  crsf_access_t    busWr;
  crsf_bus_state_t busState;
  logic            busTake;
  logic [15:0]     next_flags;

  function automatic logic [15:0] merge(input logic [15:0] old, input crsf_size_t size,
                                        input logic [31:0] data);
    case (size)
      SZ_LOW:  merge = {old[15:8], data[7:0]};
      SZ_HIGH: merge = {data[7:0], old[7:0]};
      default: merge = data[15:0];
    endcase
  endfunction

  // write strobe for one selector; the decode is shared by the unbanked registers except the flags
  function automatic logic hits(input crsf_access_t a, input logic [3:0] sel);
    hits = a.en && (a.sel == sel);
  endfunction

  // new value of a 16-bit half that may also be the upper half of a pair
  function automatic logic [15:0] nextHalf(input logic [15:0] old, input crsf_access_t a,
                                           input logic [3:0] self, input logic paired,
                                           input logic [3:0] low);
    nextHalf = old;
    if (a.en && a.sel == self)
      nextHalf = merge(old, a.size, a.data);
    else if (paired && a.en && a.size == SZ_LONG && a.sel == low)
      nextHalf = a.data[31:16];
  endfunction

  function automatic logic [31:0] part(input logic [15:0] v, input crsf_size_t size);
    case (size)
      SZ_LOW:  part = {24'h000000, v[7:0]};
      SZ_HIGH: part = {24'h000000, v[15:8]};
      default: part = {16'h0000, v};
    endcase
  endfunction

  function automatic logic [31:0] readReg(input logic [3:0] sel, input crsf_size_t size);
    case (sel)
      SEL_DATA0: readReg = (size == SZ_LONG) ? {dataReg[bankSel][2], dataReg[bankSel][0]}
                                             : part(dataReg[bankSel][0], size);
      SEL_DATA1: readReg = (size == SZ_LONG) ? {dataReg[bankSel][3], dataReg[bankSel][1]}
                                             : part(dataReg[bankSel][1], size);
      SEL_DATA2: readReg = {16'h0000, dataReg[bankSel][2]};
      SEL_DATA3: readReg = {16'h0000, dataReg[bankSel][3]};
      SEL_ADDR0: readReg = (size == SZ_LONG) ? {addrReg[bankSel][1], addrReg[bankSel][0]}
                                             : {16'h0000, addrReg[bankSel][0]};
      SEL_ADDR1: readReg = {16'h0000, addrReg[bankSel][1]};
      SEL_FRAME:  readReg = {16'h0000, frameBase[bankSel]};
      SEL_PROG:   readReg = {12'h000, programCounter};
      SEL_VTB:    readReg = {12'h000, vectorTableBase};
      SEL_USTACK: readReg = {16'h0000, userStackPtr};
      SEL_ISTACK: readReg = {16'h0000, irqStackPtr};
      SEL_STATIC: readReg = {16'h0000, staticBase};
      SEL_FLAGS: readReg = {16'h0000, processorFlags & FLAGS_WMASK};
      SEL_SP:    readReg = {16'h0000, activeSp};
      default:   readReg = 32'h00000000;
    endcase
  endfunction

  assign bankSel = processorFlags[FLAG_B];
  assign activeSp = processorFlags[FLAG_U] ? userStackPtr : irqStackPtr;

  // bus slave: one wait cycle, then the answer; a datapath write stalls a bus write
  assign busTake = (busState == BUS_ACK) && write && !dpWr.en;
  assign waitrequest = !((busState == BUS_ACK) && !(write && dpWr.en));

  always_comb
  begin
    busWr.en   = busTake && (address[1:0] == 2'h0);
    busWr.sel  = address[5:2];
    busWr.size = SZ_WORD;
    busWr.data = writedata;
    wr = dpWr.en ? dpWr : busWr;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      busState <= BUS_IDLE;
    else
    begin
      case (busState)
        BUS_IDLE: if (read || write) busState <= BUS_ACK;
        BUS_ACK:  if (!waitrequest) busState <= BUS_IDLE;
        default:  busState <= BUS_IDLE;
      endcase
    end
  end

  // read data captured on entry to the answer cycle, stands until next read
  always_ff @(posedge clk)
  begin
    if (reset)
      readdata <= 32'h00000000;
    else if (busState == BUS_IDLE && read)
      readdata <= (address[1:0] == 2'h0) ? readReg(address[5:2], SZ_WORD) : 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      dpRdData <= 32'h00000000;
    else if (dpRd.en)
      dpRdData <= readReg(dpRd.sel, dpRd.size);
  end

  // banked registers: a bank takes writes only while the bank flag names it,
  // so the idle bank keeps a whole context for a fast switch
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    for (genvar i = 0; i < 4; i++)
    begin : g_data
      always_ff @(posedge clk)
      begin
        if (reset)
          dataReg[b][i] <= REG_RESET;
        else if (bankSel == 1'(b))
          dataReg[b][i] <= nextHalf(dataReg[b][i], wr, SEL_DATA0 + 4'(i), i >= 2,
                                    SEL_DATA0 + 4'(i % 2));
      end
    end

    always_ff @(posedge clk)
    begin
      if (reset)
        addrReg[b][0] <= REG_RESET;
      else if (bankSel == 1'(b))
        addrReg[b][0] <= nextHalf(addrReg[b][0], wr, SEL_ADDR0, 1'b0, SEL_ADDR0);
    end

    // upper half of the long address pair
    always_ff @(posedge clk)
    begin
      if (reset)
        addrReg[b][1] <= REG_RESET;
      else if (bankSel == 1'(b))
        addrReg[b][1] <= nextHalf(addrReg[b][1], wr, SEL_ADDR1, 1'b1, SEL_ADDR0);
    end

    always_ff @(posedge clk)
    begin
      if (reset)
        frameBase[b] <= REG_RESET;
      else if (bankSel == 1'(b))
        frameBase[b] <= nextHalf(frameBase[b], wr, SEL_FRAME, 1'b0, SEL_FRAME);
    end
  end

  // shared registers, untouched by the bank flag
  always_ff @(posedge clk)
  begin
    if (reset)
      programCounter <= PROG_RESET;
    else if (hits(wr, SEL_PROG))
      programCounter <= wr.data[19:0];
  end

  // the table base moves only on an explicit write, never on an interrupt
  always_ff @(posedge clk)
  begin
    if (reset)
      vectorTableBase <= VTB_RESET;
    else if (hits(wr, SEL_VTB))
      vectorTableBase <= wr.data[19:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      staticBase <= REG_RESET;
    else if (hits(wr, SEL_STATIC))
      staticBase <= merge(staticBase, wr.size, wr.data);
  end

  // the stack alias follows the select flag as it stands before this write,
  // so an acknowledge in the same cycle does not redirect it
  always_ff @(posedge clk)
  begin
    if (reset)
      userStackPtr <= REG_RESET;
    else if (hits(wr, SEL_USTACK) || (hits(wr, SEL_SP) && processorFlags[FLAG_U]))
      userStackPtr <= merge(userStackPtr, wr.size, wr.data);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irqStackPtr <= REG_RESET;
    else if (hits(wr, SEL_ISTACK) || (hits(wr, SEL_SP) && !processorFlags[FLAG_U]))
      irqStackPtr <= merge(irqStackPtr, wr.size, wr.data);
  end

  // flags: write, then alu, then interrupt clears, which win over all
  always_comb
  begin
    next_flags = processorFlags;
    if (wr.en && wr.sel == SEL_FLAGS)
      next_flags = merge(processorFlags, wr.size, wr.data);
    if (alu.updC)
      next_flags[FLAG_C] = alu.carry;
    if (alu.updZS)
    begin
      next_flags[FLAG_Z] = alu.isByte ? (alu.result[7:0] == 8'h00)
                                      : (alu.result == 16'h0000);
      next_flags[FLAG_S] = alu.isByte ? alu.result[7] : alu.result[15];
    end
    if (alu.updO)
      next_flags[FLAG_O] = alu.overflow;
    if (ev.hwAck)
    begin
      next_flags[FLAG_I] = 1'b0;
      next_flags[FLAG_U] = 1'b0;
    end
    if (ev.stepAck)
    begin
      next_flags[FLAG_D] = 1'b0;
      next_flags[FLAG_I] = 1'b0;
    end
    if (ev.swInt)
    begin
      next_flags[FLAG_I] = 1'b0;
      if (ev.swNum <= SWINT_U_MAX)
        next_flags[FLAG_U] = 1'b0;
    end
    next_flags = next_flags & FLAGS_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      processorFlags <= FLAGS_RESET;
    else
      processorFlags <= next_flags;
  end

  // non-maskable requests bypass the enable bit but not the level
  assign irqAccept = irq.req && (irq.prio > processorFlags[PRIO_LSB +: PRIO_W])
                     && (!irq.maskable || processorFlags[FLAG_I]);
  assign stepIrq = processorFlags[FLAG_D] && ev.instrDone;

endmodule // crsf_regs

/* crsf_pkg.sv */
package crsf_pkg;

  // register selector; on the bus the byte offset is four times the selector
  localparam logic [3:0] SEL_DATA0 = 4'h0;
  localparam logic [3:0] SEL_DATA1 = 4'h1;
  localparam logic [3:0] SEL_DATA2 = 4'h2;
  localparam logic [3:0] SEL_DATA3 = 4'h3;
  localparam logic [3:0] SEL_ADDR0 = 4'h4;
  localparam logic [3:0] SEL_ADDR1 = 4'h5;
  localparam logic [3:0] SEL_FRAME  = 4'h6;
  localparam logic [3:0] SEL_PROG   = 4'h7;
  localparam logic [3:0] SEL_VTB    = 4'h8;
  localparam logic [3:0] SEL_USTACK = 4'h9;
  localparam logic [3:0] SEL_ISTACK = 4'ha;
  localparam logic [3:0] SEL_STATIC = 4'hb;
  localparam logic [3:0] SEL_FLAGS = 4'hc;
  localparam logic [3:0] SEL_SP    = 4'hd;

  // flag bit positions
  localparam int FLAG_C   = 0;
  localparam int FLAG_D   = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_S   = 3;
  localparam int FLAG_B   = 4;
  localparam int FLAG_O   = 5;
  localparam int FLAG_I   = 6;
  localparam int FLAG_U   = 7;
  localparam int PRIO_LSB = 12;
  localparam int PRIO_W   = 3;

  localparam logic [15:0] FLAGS_WMASK = 16'h70ff;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [19:0] PROG_RESET  = 20'h00000;
  localparam logic [19:0] VTB_RESET   = 20'h00000;
  localparam logic [5:0]  SWINT_U_MAX = 6'h1f;

  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_LOW  = 2'h1,
    SZ_HIGH = 2'h2,
    SZ_LONG = 2'h3
  } crsf_size_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } crsf_bus_state_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    crsf_size_t  size;
    logic [31:0] data;
  } crsf_access_t;

  typedef struct packed {
    logic        updC;
    logic        updZS;
    logic        updO;
    logic        carry;
    logic        overflow;
    logic        isByte;
    logic [15:0] result;
  } crsf_alu_t;

  typedef struct packed {
    logic       hwAck;
    logic       stepAck;
    logic       swInt;
    logic [5:0] swNum;
    logic       instrDone;
  } crsf_event_t;

  typedef struct packed {
    logic       req;
    logic [2:0] prio;
    logic       maskable;
  } crsf_irq_t;

endpackage

/* crsf_regs_sva.sv */
module crsf_regs_sva
  import crsf_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // events and state
  input wire crsf_alu_t   alu,
  input wire crsf_event_t ev,
  input wire crsf_irq_t   irq,
  input wire logic        irqAccept,
  input wire logic        stepIrq,
  input wire logic [15:0] processorFlags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_rsv; processorFlags[11:8] == 4'h0 && !processorFlags[15]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag bits set");
  property p_acc;
    irqAccept == (irq.req && irq.prio > processorFlags[14:12]
                  && (!irq.maskable || processorFlags[6]));
  endproperty
  a_acc: assert property (p_acc) else $error("accept mismatch");
  property p_step; stepIrq == (processorFlags[1] && ev.instrDone); endproperty
  a_step: assert property (p_step) else $error("step mismatch");
  property p_hw; ev.hwAck |=> !processorFlags[7] && !processorFlags[6]; endproperty
  a_hw: assert property (p_hw) else $error("ack left flags set");
  property p_sack; ev.stepAck |=> !processorFlags[1]; endproperty
  a_sack: assert property (p_sack) else $error("step ack left flag");
  property p_sw; ev.swInt && ev.swNum <= 6'h1f |=> !processorFlags[7]; endproperty
  a_sw: assert property (p_sw) else $error("soft int left stack flag");
  property p_carry; alu.updC |=> processorFlags[0] == $past(alu.carry); endproperty
  a_carry: assert property (p_carry) else $error("carry not taken");
  property p_zero;
    alu.updZS && !alu.isByte |=> processorFlags[2] == ($past(alu.result) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign;
    alu.updZS && !alu.isByte |=> processorFlags[3] == $past(alu.result[15]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_zbyte;
    alu.updZS && alu.isByte |=> processorFlags[2] == ($past(alu.result[7:0]) == 8'h00)
                                && processorFlags[3] == $past(alu.result[7]);
  endproperty
  a_zbyte: assert property (p_zbyte) else $error("byte zero or sign wrong");
  property p_ovf; alu.updO |=> processorFlags[5] == $past(alu.overflow); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
endmodule // crsf_regs_sva

bind crsf_regs crsf_regs_sva i_crsf_regs_sva (.clk(clk), .reset(reset), .alu(alu), .ev(ev),
  .irq(irq), .irqAccept(irqAccept), .stepIrq(stepIrq), .processorFlags(processorFlags));

/* crsf_alu_model.sv */
module crsf_alu_model
  import crsf_pkg::*;
(
  // operation request
  input wire logic        en,
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  input wire logic        bytes,
  // flag update
  output crsf_alu_t       alu
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] sum;
  // word add; byte mode only narrows the zero and sign view of the result
  assign sum = {1'b0, opA} + {1'b0, opB};
  assign alu = '{en, en, en, sum[16], (opA[15] == opB[15]) && (sum[15] != opA[15]),
                 bytes, sum[15:0]};
endmodule // crsf_alu_model

/* cpu_register_set_flags_test.sv */
module cpu_register_set_flags_test
  import crsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] flAddr = {SEL_FLAGS, 2'b00};
  localparam logic [5:0] spAddr = {SEL_SP, 2'b00};
  logic         clk = 0, reset = 1, read = 0, write = 0, aluEn = 0, waitrequest;
  logic         irqAccept, stepIrq;
  logic [5:0]   address = '0;
  logic [31:0]  writedata = '0, readdata, v, q[$], e0[12], e1[7];
  logic [15:0]  opA = '0, opB = '0, fl;
  logic [16:0]  s;
  crsf_access_t dpWr = '0;
  crsf_access_t dpRd = '0;
  logic [31:0]  dpRdData;
  logic [19:0]  progCount;
  logic [15:0]  flagsOut;
  logic         aluByte = 0;
  crsf_alu_t    alu;
  crsf_event_t  ev = '0;
  crsf_irq_t    irq = '0;
  int           seed = 29019, miscompares = 0, comparisons = 0, cyc = 0;

  crsf_regs i_crsf_regs (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .dpRd(dpRd), .dpRdData(dpRdData), .dpWr(dpWr), .alu(alu), .ev(ev), .irq(irq),
    .irqAccept(irqAccept), .stepIrq(stepIrq), .programCounter(progCount),
    .processorFlags(flagsOut));
  crsf_alu_model i_crsf_alu_model (.en(aluEn), .opA(opA), .opB(opB), .bytes(aluByte),
    .alu(alu));

  initial forever #4 clk = ~clk;

  task check(string n, logic [31:0] seen, logic [31:0] e);
    comparisons++;
    if (seen !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, seen);
    end
  endtask
  task bw(logic [5:0] a, logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1;
    @(posedge clk iff !waitrequest);
    write <= 0;
  endtask
  task br(logic [5:0] a, logic [31:0] d);
    q.push_back(d);
    @(posedge clk);
    address <= a;
    read <= 1;
    @(posedge clk iff !waitrequest);
    read <= 0;
  endtask
  task pulse(crsf_event_t e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
  endtask
  task dw(logic [3:0] sl, crsf_size_t sz, logic [31:0] d);
    @(posedge clk);
    dpWr <= '{1'b1, sl, sz, d};
    @(posedge clk);
    dpWr <= '0;
  endtask
  task dr(logic [3:0] sl, crsf_size_t sz, logic [31:0] e);
    @(posedge clk);
    dpRd <= '{1'b1, sl, sz, 32'h0};
    @(posedge clk);
    dpRd <= '0;
    @(negedge clk);
    check("dpRdData", dpRdData, e);
  endtask
  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read data judged in the answer cycle, oldest note first
  always @(posedge clk iff (read && !waitrequest))
    check("readdata", readdata, q.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    for (int i = 0; i < 16; i++)
      br(6'(i * 4), 0);
    br(6'h01, 0);
    bw(6'h3c, 32'h1234);
    br(6'h3c, 0);
    for (int i = 0; i < 12; i++)
    begin
      v = $random(seed);
      e0[i] = (i == 7 || i == 8) ? v & 32'hfffff : v & 32'hffff;
      bw(6'(i * 4), v);
    end
    bw(flAddr, 32'h10);
    for (int i = 0; i < 7; i++)
    begin
      v = $random(seed);
      e1[i] = v & 32'hffff;
      bw(6'(i * 4), v);
    end
    for (int i = 0; i < 12; i++)
      br(6'(i * 4), i < 7 ? e1[i] : e0[i]);
    bw(flAddr, 0);
    for (int i = 0; i < 7; i++)
      br(6'(i * 4), e0[i]);
    br(spAddr, e0[10]);
    check("programCounter", progCount, e0[7]);
    bw(flAddr, 32'hffff);
    br(flAddr, 32'h70ff);
    check("processorFlags", flagsOut, 32'h70ff);
    br(spAddr, e0[9]);
    bw(spAddr, 32'h0000beef);
    br(6'h24, 32'h0000beef);
    // event codes: hwAck, stepAck, soft int 32, soft int 31
    pulse(10'h200);
    br(flAddr, 32'h703f);
    bw(flAddr, 32'hffff);
    pulse(10'h100);
    br(flAddr, 32'h70bd);
    bw(flAddr, 32'hffff);
    pulse(10'h0c0);
    br(flAddr, 32'h70bf);
    pulse(10'h0be);
    br(flAddr, 32'h703f);
    for (int k = 0; k < 3; k++)
    begin
      v = $random(seed);
      dw(k == 2 ? 4'h4 : 4'(k), SZ_LONG, v);
      br(k == 2 ? 6'h10 : 6'(k * 4), v[15:0]);
      br(k == 2 ? 6'h14 : 6'(k * 4 + 8), v[31:16]);
      dr(k == 2 ? 4'h4 : 4'(k), SZ_LONG, v);
    end
    dw(1, SZ_WORD, 32'h1234);
    dw(1, SZ_HIGH, 32'h5a);
    dw(1, SZ_LOW, 32'hc3);
    br(6'h04, 32'h5ac3);
    dr(4'h1, SZ_HIGH, 32'h5a);
    dr(4'h1, SZ_LOW, 32'hc3);
    bw(flAddr, 0);
    fl = 0;
    for (int k = 0; k < 4; k++)
    begin
      v = k == 0 ? 32'h80008000 : $random(seed);
      @(posedge clk);
      opA <= v[15:0];
      opB <= v[31:16];
      aluEn <= 1;
      aluByte <= k == 3;
      @(posedge clk);
      aluEn <= 0;
      s = {1'b0, v[15:0]} + v[31:16];
      fl[0] = s[16];
      fl[2] = (k == 3) ? (s[7:0] == 0) : (s[15:0] == 0);
      fl[3] = (k == 3) ? s[7] : s[15];
      fl[5] = (v[15] == v[31]) && (s[15] != v[15]);
      br(flAddr, fl);
    end
    bw(flAddr, 32'h3002);
    for (int i = 0; i < 32; i++)
    begin
      if (i == 16)
        bw(flAddr, 32'h3042);
      @(posedge clk);
      irq <= '{1'b1, 3'(i), i[3]};
      @(negedge clk);
      check("irqAccept", irqAccept, (i % 8 > 3) && (!i[3] || i[4]));
    end
    @(posedge clk);
    irq <= '0;
    ev <= 10'h001;
    @(negedge clk);
    check("stepIrq", stepIrq, 1);
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule // cpu_register_set_flags_test
